// *** logic/rpspm_pkg.sv ***
// Constants shared by the strap capture and pin mux block.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
package rpspm_pkg;

  // ==========================================================
  // APB register offsets and reset values
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STRAP  = 12'h004;
  localparam logic [11:0] OFF_CLKCFG = 12'h008;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic        CLKCFG_RST = 1'b0;
  localparam int          CTRL_DUPLEX_BIT = 8;
  localparam int          CTRL_ISO_BIT    = 10;

  // ==========================================================
  // Strap pin order on the strap input vector
  localparam int STRAP_W        = 7;
  localparam int STRAP_AD0      = 0;
  localparam int STRAP_AD1      = 1;
  localparam int STRAP_AD2      = 2;
  localparam int STRAP_DUPLEX   = 3;
  localparam int STRAP_MODE2    = 4;
  localparam int STRAP_UNIQUE   = 5;
  localparam int STRAP_ISO      = 6;
  localparam logic [6:0] STRAP_RST = 7'h00;

  // ==========================================================
  // Management serial frame
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [5:0] HDR_LAST  = 6'h0B;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [4:0] MGMT_REG_CTRL = 5'h00;

  typedef enum logic [5:0] {
    MD_PRE  = 6'b000001,
    MD_ST   = 6'b000010,
    MD_HDR  = 6'b000100,
    MD_TA1  = 6'b001000,
    MD_TA2  = 6'b010000,
    MD_DATA = 6'b100000
  } rpspm_mdio_e;

endpackage : rpspm_pkg

// *** logic/rpspm_strap_if.sv ***
// Captured strap values passed from the capture module to the top.
// Assumes both ends run on the system clock.
interface rpspm_strap_if;
  logic [2:0] mgmtStationAddr;
  logic       duplexHalf;
  logic       ifaceModeStrapBit2;
  logic       addrZeroUniqueStrap;
  logic       isolate;
  logic       done;
  logic       capture;

  modport cap (
    output mgmtStationAddr, duplexHalf, ifaceModeStrapBit2,
           addrZeroUniqueStrap, isolate, done, capture
  );
  modport sink (
    input  mgmtStationAddr, duplexHalf, ifaceModeStrapBit2,
           addrZeroUniqueStrap, isolate, done, capture
  );
endinterface : rpspm_strap_if

// *** logic/rpspm_sync.sv ***
// Two flip-flop synchroniser for levels and toggles.
// Assumes each bit is stable or changes one bit at a time.
module rpspm_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule : rpspm_sync

// *** logic/rpspm_strap.sv ***
// Strap capture: samples the dual-use pins at reset release.
// Assumes srst is held high for at least three clock edges.
module rpspm_strap
  import rpspm_pkg::*;
(
  // System
  input  wire logic               clock,
  input  wire logic               srst,
  // Raw strap pin levels
  input  wire logic [STRAP_W-1:0] pinIn,
  // Captured values
  rpspm_strap_if.cap              st
);
  logic [STRAP_W-1:0] pinSync;
  logic [STRAP_W-1:0] val_r;
  logic               pend_r;
  logic               done_r;
  logic               cap_r;
  wire                capNow = pend_r & ~srst;

  rpspm_sync #(.W(STRAP_W)) uPinSync (
    .clk (clock),
    .d   (pinIn),
    .q   (pinSync)
  );

  // ==========================================================
  // Capture on the first edge after reset release
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_r <= 1'b1;
      done_r <= 1'b0;
      cap_r  <= 1'b0;
      val_r  <= STRAP_RST;
    end else begin
      pend_r <= 1'b0;
      cap_r  <= capNow;
      if (capNow) begin
        done_r <= 1'b1;
        val_r  <= pinSync;
      end
    end
  end

  assign st.mgmtStationAddr     = val_r[STRAP_AD2:STRAP_AD0];
  assign st.duplexHalf          = val_r[STRAP_DUPLEX];
  assign st.ifaceModeStrapBit2  = val_r[STRAP_MODE2];
  assign st.addrZeroUniqueStrap = val_r[STRAP_UNIQUE];
  assign st.isolate             = val_r[STRAP_ISO];
  assign st.done                = done_r;
  assign st.capture             = cap_r;
endmodule : rpspm_strap

// *** logic/rpspm_top.sv ***
// rpspm_top: strap capture, RMII receive pin mux, APB registers
// and the management serial port of a 10/100 transceiver.
// Assumes a 25 MHz clock, mdc driven by the station, pads outside.
// What this block does
// - Latch three address straps at reset release
// - Latch duplex strap, then drive receive bit0
// - Latch data-valid pin as mode bit two
// - Latch reference clock pin as broadcast-off
// - Latch receive error pin as isolate
// - Drive receive pins toward MAC after reset
// - 25 MHz mode forwards 50 MHz reference clock
// - 50 MHz mode leaves reference pin undriven
// - Management data runs on station's mdc
// - Data and interrupt pins only pull low
// - Duplex strap seeds control bit eight
// - Isolate strap seeds control bit ten
// - Address zero broadcast unless strap says unique
//
// Decided for this implementation: the APB register port and the register offsets.
module rpspm_top
  import rpspm_pkg::*;
#(
  parameter int AW = 12
) (
  // System
  input  wire logic               clock,
  input  wire logic               srst,
  // APB slave
  input  wire logic [AW-1:0]      paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Receive path and clock sources from the core
  input  wire logic [1:0]         rxDataCore,
  input  wire logic               rxDvCore,
  input  wire logic               rxErrCore,
  input  wire logic               irqReq,
  input  wire logic               pllClk50,
  // Strap levels of the dual-use pins
  input  wire logic [STRAP_W-1:0] strapPinIn,
  // RMII pins toward the MAC
  output logic                    rxd1Out,
  output logic                    rxd1Oe,
  output logic                    rxd0Out,
  output logic                    rxd0Oe,
  output logic                    crsDvOut,
  output logic                    crsDvOe,
  output logic                    rxErrOut,
  output logic                    rxErrOe,
  output logic                    refClkOut,
  output logic                    refClkOe,
  // Management port
  input  wire logic               mdc,
  input  wire logic               mdioIn,
  output logic                    mdioOut,
  output logic                    mdioOe,
  // Interrupt pin
  output logic                    irqOutN,
  output logic                    irqOe
);

  // ==========================================================
  // Strap capture
  rpspm_strap_if st ();

  rpspm_strap uStrap (
    .clock (clock),
    .srst  (srst),
    .pinIn (strapPinIn),
    .st    (st.cap)
  );

  function automatic logic regHit(
    input logic [AW-1:0] addr,
    input logic [11:0]   off
  );
    regHit = (addr == AW'(off));
  endfunction : regHit

  // ==========================================================
  // Declarations
  logic [15:0] ctrl_r;
  logic [15:0] ctrlNxt;
  logic        clkMode50_r;
  logic [31:0] prdata_r;
  logic [1:0]  rxData_r;
  logic        rxDv_r;
  logic        rxErr_r;
  logic        irqReq_r;
  logic [15:0] mirWord_r;
  logic        mirReq_r;
  logic        mirValid_r;
  logic        ackSync;
  logic        wrTglSync;
  logic        wrTglSeen_r;
  // Link domain
  logic        mrst;
  logic [4:0]  lnkStrap;
  logic        mreqSync;
  rpspm_mdio_e mdState_r;
  rpspm_mdio_e mdStateNxt;
  logic [5:0]  cnt_r;
  logic [5:0]  cntNxt;
  logic [11:0] hdr_r;
  logic [11:0] hdrNxt;
  logic [15:0] sh_r;
  logic [15:0] shNxt;
  logic        isRd_r;
  logic        isRdNxt;
  logic        hit_r;
  logic        hitNxt;
  logic        oe_r;
  logic        oeNxt;
  logic        bit_r;
  logic        bitNxt;
  logic [15:0] mirror_r;
  logic        ack_r;
  logic        wrTgl_r;
  logic        wrTglNxt;
  logic [15:0] wrWord_r;
  logic [15:0] wrWordNxt;

  // ==========================================================
  // APB decode
  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable;
  wire hitCtrl   = regHit(paddr, OFF_CTRL);
  wire hitStrap  = regHit(paddr, OFF_STRAP);
  wire hitClk    = regHit(paddr, OFF_CLKCFG);
  wire mapped    = hitCtrl | hitStrap | hitClk;
  wire apbWr     = apbAccess & pwrite;
  wire wrCtrl    = apbWr & hitCtrl;
  wire wrClk     = apbWr & hitClk;
  wire mirBusy   = mirReq_r ^ ackSync;

  wire [31:0] strapWord = {
    23'h000000, mirBusy, st.done, st.isolate,
    st.addrZeroUniqueStrap, st.ifaceModeStrapBit2,
    st.duplexHalf, st.mgmtStationAddr
  };

  wire [31:0] rdMux = hitCtrl  ? {16'h0000, ctrl_r} :
                      hitStrap ? strapWord :
                      hitClk   ? {31'h00000000, clkMode50_r} :
                                 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~mapped;
  assign prdata  = prdata_r;

  // Read data is fetched in setup so the access cycle needs no wait
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_r <= 32'h00000000;
    end else if (apbSetup & ~pwrite) begin
      prdata_r <= rdMux;
    end
  end

  // ==========================================================
  // Control register
  // A write from the management port lands as a toggle event
  wire mdioWr = wrTglSync ^ wrTglSeen_r;

  always_comb begin
    ctrlNxt = ctrl_r;
    if (st.capture) begin
      ctrlNxt[CTRL_DUPLEX_BIT] = st.duplexHalf;
      ctrlNxt[CTRL_ISO_BIT]    = st.isolate;
    end
    if (mdioWr) begin
      ctrlNxt = wrWord_r;
    end
    // APB wins a same-cycle collision with a serial write
    if (wrCtrl) begin
      ctrlNxt = pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r      <= CTRL_RST;
      clkMode50_r <= CLKCFG_RST;
      wrTglSeen_r <= 1'b0;
    end else begin
      ctrl_r      <= ctrlNxt;
      wrTglSeen_r <= wrTglSync;
      if (wrClk) begin
        clkMode50_r <= pwdata[0];
      end
    end
  end

  // ==========================================================
  // Control word toward the link domain
  // Word is held stable while its request toggle is in flight
  wire mirSend = ~mirBusy & (~mirValid_r | (mirWord_r != ctrl_r));

  always_ff @(posedge clock) begin
    if (srst) begin
      mirWord_r  <= CTRL_RST;
      mirReq_r   <= 1'b0;
      mirValid_r <= 1'b0;
    end else if (mirSend) begin
      mirWord_r  <= ctrl_r;
      mirReq_r   <= ~mirReq_r;
      mirValid_r <= 1'b1;
    end
  end

  rpspm_sync #(.W(1)) uAckSync (
    .clk (clock),
    .d   (ack_r),
    .q   (ackSync)
  );

  rpspm_sync #(.W(1)) uWrSync (
    .clk (clock),
    .d   (wrTgl_r),
    .q   (wrTglSync)
  );

  // ==========================================================
  // RMII receive pins and clock pin
  // Drivers stay off during reset and while isolated
  // Isolate strap also covers the cycle before ctrl bit ten loads
  wire pinsLive = st.done & ~srst;
  wire isoNow   = ctrl_r[CTRL_ISO_BIT] | (st.capture & st.isolate);
  wire rmiiOe   = pinsLive & ~isoNow;

  always_ff @(posedge clock) begin
    if (srst) begin
      rxData_r <= 2'h0;
      rxDv_r   <= 1'b0;
      rxErr_r  <= 1'b0;
      irqReq_r <= 1'b0;
    end else begin
      rxData_r <= rxDataCore;
      rxDv_r   <= rxDvCore;
      rxErr_r  <= rxErrCore;
      irqReq_r <= irqReq;
    end
  end

  assign rxd1Out  = rxData_r[1];
  assign rxd0Out  = rxData_r[0];
  assign crsDvOut = rxDv_r;
  assign rxErrOut = rxErr_r;
  assign rxd1Oe   = rmiiOe;
  assign rxd0Oe   = rmiiOe;
  assign crsDvOe  = rmiiOe;
  assign rxErrOe  = rmiiOe;
  // Forwarded clock, not a data path; the pad must be timed for it
  assign refClkOut = pllClk50;
  assign refClkOe  = rmiiOe & ~clkMode50_r;

  // Open-drain style: only ever pulls low
  assign irqOutN = 1'b0;
  assign irqOe   = pinsLive & irqReq_r;

  // ==========================================================
  // Link domain: management serial port on mdc
  rpspm_sync #(.W(1)) uMrstSync (
    .clk (mdc),
    .d   (srst),
    .q   (mrst)
  );

  // Straps are static once done, so a level crossing is enough
  rpspm_sync #(.W(5)) uStrapSync (
    .clk (mdc),
    .d   ({st.addrZeroUniqueStrap, st.mgmtStationAddr, st.done}),
    .q   (lnkStrap)
  );

  rpspm_sync #(.W(1)) uReqSync (
    .clk (mdc),
    .d   (mirReq_r),
    .q   (mreqSync)
  );

  wire [11:0] hdrShift = {hdr_r[10:0], mdioIn};
  wire [1:0]  opCode   = hdrShift[11:10];
  wire [4:0]  adField  = hdrShift[9:5];
  wire [4:0]  regField = hdrShift[4:0];
  wire        lnkDone  = lnkStrap[0];
  wire [2:0]  lnkAddr  = lnkStrap[3:1];
  wire        lnkUniq  = lnkStrap[4];
  wire        opValid  = (opCode == OP_READ) | (opCode == OP_WRITE);
  wire        bcastHit = (adField == 5'h00) & ~lnkUniq;
  wire        ownHit   = adField == {2'h0, lnkAddr};
  wire        addrHit  = lnkDone & opValid & (ownHit | bcastHit);
  wire        regCtrl  = hdr_r[4:0] == MGMT_REG_CTRL;
  wire        preFull  = cnt_r == PRE_LEN;

  always_comb begin
    mdStateNxt = mdState_r;
    cntNxt     = cnt_r;
    hdrNxt     = hdr_r;
    shNxt      = sh_r;
    isRdNxt    = isRd_r;
    hitNxt     = hit_r;
    oeNxt      = oe_r;
    bitNxt     = bit_r;
    wrTglNxt   = wrTgl_r;
    wrWordNxt  = wrWord_r;
    unique case (mdState_r)
      MD_PRE: begin
        if (mdioIn) begin
          cntNxt = preFull ? cnt_r : cnt_r + 6'h01;
        end else begin
          cntNxt = 6'h00;
          if (preFull) begin
            mdStateNxt = MD_ST;
          end
        end
      end
      MD_ST: begin
        cntNxt     = 6'h00;
        mdStateNxt = mdioIn ? MD_HDR : MD_PRE;
      end
      MD_HDR: begin
        hdrNxt = hdrShift;
        cntNxt = cnt_r + 6'h01;
        if (cnt_r == HDR_LAST) begin
          mdStateNxt = MD_TA1;
          isRdNxt    = opCode == OP_READ;
          hitNxt     = addrHit;
        end
      end
      MD_TA1: begin
        mdStateNxt = MD_TA2;
        if (hit_r & isRd_r) begin
          oeNxt  = 1'b1;
          bitNxt = 1'b0;
          shNxt  = regCtrl ? mirror_r : 16'h0000;
        end
      end
      MD_TA2: begin
        mdStateNxt = MD_DATA;
        cntNxt     = 6'h00;
        bitNxt     = sh_r[15];
        shNxt      = {sh_r[14:0], 1'b0};
      end
      MD_DATA: begin
        cntNxt = cnt_r + 6'h01;
        if (isRd_r) begin
          bitNxt = sh_r[15];
          shNxt  = {sh_r[14:0], 1'b0};
        end else begin
          shNxt  = {sh_r[14:0], mdioIn};
        end
        if (cnt_r == DATA_LAST) begin
          mdStateNxt = MD_PRE;
          cntNxt     = 6'h00;
          oeNxt      = 1'b0;
          if (hit_r & ~isRd_r & regCtrl) begin
            wrWordNxt = {sh_r[14:0], mdioIn};
            wrTglNxt  = ~wrTgl_r;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mdc) begin
    if (mrst) begin
      mdState_r <= MD_PRE;
      cnt_r     <= 6'h00;
      hdr_r     <= 12'h000;
      sh_r      <= 16'h0000;
      isRd_r    <= 1'b0;
      hit_r     <= 1'b0;
      oe_r      <= 1'b0;
      bit_r     <= 1'b0;
      wrTgl_r   <= 1'b0;
      wrWord_r  <= CTRL_RST;
    end else begin
      mdState_r <= mdStateNxt;
      cnt_r     <= cntNxt;
      hdr_r     <= hdrNxt;
      sh_r      <= shNxt;
      isRd_r    <= isRdNxt;
      hit_r     <= hitNxt;
      oe_r      <= oeNxt;
      bit_r     <= bitNxt;
      wrTgl_r   <= wrTglNxt;
      wrWord_r  <= wrWordNxt;
    end
  end

  // Mirror of the control word for serial reads
  always_ff @(posedge mdc) begin
    if (mrst) begin
      mirror_r <= CTRL_RST;
      ack_r    <= 1'b0;
    end else if (mreqSync != ack_r) begin
      mirror_r <= mirWord_r;
      ack_r    <= mreqSync;
    end
  end

  // A one bit releases the line; the pull-up makes the high
  assign mdioOut = 1'b0;
  assign mdioOe  = oe_r & ~bit_r;

endmodule : rpspm_top

// *** tb/rpspm_top_asserts.sv ***
// Checker for rpspm_top: pin enables, receive copies and strap effects.
// Assumes it is bound to rpspm_top and sees only its ports.
module rpspm_top_asserts
  import rpspm_pkg::*;
(
  // System
  input wire logic               clock,
  input wire logic               srst,
  // Core side
  input wire logic [1:0]         rxDataCore,
  input wire logic               rxDvCore,
  input wire logic               rxErrCore,
  input wire logic               irqReq,
  input wire logic               pllClk50,
  input wire logic [STRAP_W-1:0] strapPinIn,
  // Pins
  input wire logic               rxd1Out,
  input wire logic               rxd1Oe,
  input wire logic               rxd0Out,
  input wire logic               rxd0Oe,
  input wire logic               crsDvOut,
  input wire logic               crsDvOe,
  input wire logic               rxErrOut,
  input wire logic               rxErrOe,
  input wire logic               refClkOut,
  input wire logic               refClkOe,
  input wire logic               mdioOut,
  input wire logic               irqOutN,
  input wire logic               irqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ==========================================================
  // Enables
  // Reset must not mask its own check
  oe_in_reset_a: assert property (disable iff (1'b0)
    srst |-> !(rxd1Oe || rxd0Oe || crsDvOe || rxErrOe || refClkOe))
    else $error("pin driver enabled during reset");
  oe_after_rel_a: assert property ($fell(srst) |->
    !rxd0Oe ##1 rxd0Oe == !$past(strapPinIn[STRAP_ISO], 3))
    else $error("drivers not enabled after capture");
  iso_strap_a: assert property ($fell(srst) |-> ##2
    rxd0Oe == !$past(strapPinIn[STRAP_ISO], 4))
    else $error("isolate strap not applied to drivers");
  oe_equal_a: assert property (rxd1Oe == rxd0Oe &&
    crsDvOe == rxd0Oe && rxErrOe == rxd0Oe)
    else $error("receive pin enables differ");

  // ==========================================================
  // Data and clock
  rx_copy_a: assert property (!$past(srst) |->
    {rxd1Out, rxd0Out, crsDvOut, rxErrOut} ==
    $past({rxDataCore, rxDvCore, rxErrCore}))
    else $error("receive pins not one cycle behind core");
  refclk_fwd_a: assert property (refClkOe |->
    rxd0Oe && refClkOut == pllClk50) else $error("reference clock wrong");
  irq_follow_a: assert property (!$past(srst) && !$past(srst, 2) |->
    irqOe == $past(irqReq)) else $error("interrupt pull not following");
  od_low_a: assert property (mdioOut == 1'b0 && irqOutN == 1'b0)
    else $error("open drain pin driven high");

  cover property ($fell(srst));
  cover property (rxd0Oe && !refClkOe);
  cover property (irqOe);
  cover property ($fell(srst) ##2 !rxd0Oe);
endmodule : rpspm_top_asserts

bind rpspm_top rpspm_top_asserts rpspm_top_asserts_i (
  .clock, .srst, .rxDataCore, .rxDvCore, .rxErrCore, .irqReq, .pllClk50,
  .strapPinIn, .rxd1Out, .rxd1Oe, .rxd0Out, .rxd0Oe, .crsDvOut, .crsDvOe,
  .rxErrOut, .rxErrOe, .refClkOut, .refClkOe, .mdioOut, .irqOutN, .irqOe
);

// *** tb/rpspm_mac_model.sv ***
// Management station and clock source facing the block.
// Assumes the bench calls pulses and frame; mdc rests low between.
module rpspm_mac_model (
  // Management line
  output logic      mdc,
  output logic      mdioLine,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  // Core PLL clock
  output logic      pllClk50
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stationOe;
  logic stationBit;

  // Pull-up gives the high level when nobody pulls low
  assign mdioLine = mdioOe ? mdioOut : (stationOe ? stationBit : 1'b1);

  initial begin
    mdc = 1'b0;
    stationOe = 1'b0;
    stationBit = 1'b1;
    pllClk50 = 1'b0;
    #3;
    forever #10 pllClk50 = ~pllClk50;
  end

  // ==========================================================
  // One bit: set after fall, sampled just before the rise
  task bitOut(input logic b, output logic s);
    stationBit = b;
    #16;
    s = mdioLine;
    mdc = 1'b1;
    #16;
    mdc = 1'b0;
  endtask : bitOut

  task pulses(input int n);
    repeat (n) begin
      #16 mdc = 1'b1;
      #16 mdc = 1'b0;
    end
  endtask : pulses

  // Returns second turnaround bit and 16 data bits
  task frame(input logic rd, input logic [4:0] ad, input logic [4:0] rg,
             input logic [15:0] wd, output logic [16:0] got);
    logic [63:0] seq;
    logic        s;
    int          i;
    seq = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, ad, rg, 2'b10, wd};
    got = 17'h00000;
    stationOe = 1'b1;
    for (i = 63; i >= 0; i--) begin
      if (rd && i == 17) stationOe = 1'b0;
      bitOut(seq[i], s);
      if (i <= 16) got = {got[15:0], s};
    end
    stationOe = 1'b0;
  endtask : frame
endmodule : rpspm_mac_model

// *** tb/test_rpspm_top.sv ***
// Bench for rpspm_top: straps, pin drive, clock mode, interrupt, serial.
// Assumes rpspm_mac_model plays the station and the clock source.
module test_rpspm_top
  import rpspm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  rxDataCore;
  logic        rxDvCore, rxErrCore, irqReq, pllClk50, mdc, mdioIn;
  logic [6:0]  strapPinIn;
  logic        rxd1Out, rxd1Oe, rxd0Out, rxd0Oe, crsDvOut, crsDvOe;
  logic        rxErrOut, rxErrOe, refClkOut, refClkOe;
  logic        mdioOut, mdioOe, irqOutN, irqOe;
  logic [16:0] g;
  int          nFail, samplesChecked;
  wire [7:0]   rxPins = {rxd1Out, rxd0Out, crsDvOut, rxErrOut,
                         rxd1Oe, rxd0Oe, crsDvOe, rxErrOe};

  rpspm_top #(.AW(12)) rpspm_top_i (
    .clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rxDataCore, .rxDvCore, .rxErrCore, .irqReq,
    .pllClk50, .strapPinIn, .rxd1Out, .rxd1Oe, .rxd0Out, .rxd0Oe,
    .crsDvOut, .crsDvOe, .rxErrOut, .rxErrOe, .refClkOut, .refClkOe,
    .mdc, .mdioIn, .mdioOut, .mdioOe, .irqOutN, .irqOe
  );
  rpspm_mac_model rpspm_mac_model_i (
    .mdc, .mdioLine(mdioIn), .mdioOut, .mdioOe, .pllClk50
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock; // 25 MHz input clock
  end

  // ==========================================================
  // Tasks
  task close_out();
    $display("checks %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
    end
  endtask : chk

  task endTest(input string n);
    $display("test %s done, mismatches %0d", n, nFail);
  endtask : endTest

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      nFail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task readChk(input logic [11:0] a, input logic [31:0] mask,
               input logic [31:0] exp, input logic expErr, input string m);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h00000000, d, e);
    chk(d & mask, exp, m);
    chk({31'h0, e}, {31'h0, expErr}, m);
  endtask : readChk

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task mdRd(input logic [4:0] ad, input logic [16:0] exp, input string m);
    rpspm_mac_model_i.frame(1'b1, ad, MGMT_REG_CTRL, 16'h0000, g);
    chk({15'h0, g}, {15'h0, exp}, m);
  endtask : mdRd

  // Station clocks mdc during reset so the serial side resets too,
  // and again after it so that side leaves reset before a frame
  task doReset(input logic [6:0] pins);
    @(posedge clock);
    srst <= 1'b1;
    strapPinIn <= pins;
    #7;
    rpspm_mac_model_i.pulses(4);
    @(posedge clock);
    chk({rxd1Oe, rxd0Oe, crsDvOe, rxErrOe, refClkOe}, 0,
        "oe in reset");
    srst <= 1'b0;
    @(posedge clock);
    // Pins turn to outputs; captured values must not follow
    strapPinIn <= ~pins;
    @(posedge clock);
    rpspm_mac_model_i.pulses(3);
  endtask : doReset

  // ==========================================================
  // Sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    rxDataCore = 2'h0;
    rxDvCore = 1'b0;
    rxErrCore = 1'b0;
    irqReq = 1'b0;
    strapPinIn = 7'h00;
    nFail = 0;
    samplesChecked = 0;
    doReset(7'h0D);
    readChk(OFF_STRAP, 32'hFF, 32'h8D, 1'b0,
            "strap A");
    readChk(OFF_CTRL, 32'hFFFF, 32'h0100, 1'b0,
            "ctrl A");
    readChk(12'h00C, 32'hFFFFFFFF, 32'h0, 1'b1, "unmapped");
    endTest("strap A");
    @(posedge clock);
    {rxDataCore, rxDvCore, rxErrCore} <= 4'hB;
    repeat (2) @(posedge clock);
    chk(rxPins, 8'hBF, "rx 1");
    {rxDataCore, rxDvCore, rxErrCore} <= 4'h4;
    repeat (2) @(posedge clock);
    chk(rxPins, 8'h4F, "rx 2");
    endTest("rmii");
    wr(OFF_CLKCFG, 32'h1);
    readChk(OFF_CLKCFG, 32'h1, 32'h1, 1'b0, "clkcfg");
    chk({refClkOe, rxd0Oe}, 2'b01, "50 mode");
    wr(OFF_CLKCFG, 32'h0);
    @(posedge clock);
    chk({refClkOe, rxd0Oe}, 2'b11, "25 mode");
    chk(refClkOut, pllClk50, "ref clock");
    endTest("clock mode");
    irqReq <= 1'b1;
    repeat (2) @(posedge clock);
    chk({irqOe, irqOutN}, 2'b10, "irq on");
    irqReq <= 1'b0;
    repeat (2) @(posedge clock);
    chk({irqOe, irqOutN}, 2'b00, "irq off");
    endTest("interrupt");
    #5;
    mdRd(5'h05, 17'h00100, "md own");
    mdRd(5'h00, 17'h00100, "md broadcast");
    mdRd(5'h06, 17'h1FFFF, "md other");
    rpspm_mac_model_i.frame(1'b0, 5'h05, MGMT_REG_CTRL, 16'h1234,
                            g);
    repeat (10) @(posedge clock);
    readChk(OFF_CTRL, 32'hFFFF, 32'h1234, 1'b0, "md write");
    endTest("serial");
    doReset(7'h72);
    readChk(OFF_STRAP, 32'hFF, 32'hF2, 1'b0,
            "strap B");
    readChk(OFF_CTRL, 32'hFFFF, 32'h0400, 1'b0,
            "ctrl B");
    chk({rxd0Oe, refClkOe}, 2'b00, "isolated");
    mdRd(5'h00, 17'h1FFFF, "md unique zero");
    mdRd(5'h02, 17'h00400, "md own B");
    endTest("strap B");
    close_out();
  end
endmodule : test_rpspm_top
